/* File: rdcc_pkg.sv */
// constants, register map and types of the ram driven capture compare block
package rdcc_pkg;
   // ------------------------------------------------------------
   // storage geometry
   // ------------------------------------------------------------
   localparam int unsigned RAM_WORDS = 32;
   localparam int unsigned WORD_AW = 5;
   localparam int unsigned NUM_CAP = 6;
   localparam int unsigned NUM_OUT = 8;
   localparam int unsigned TIMER_W = 20;
   localparam int unsigned EVT_W = 8;
   localparam int unsigned OPND_W = 16;
   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CAP12 = 8'h00;
   localparam logic [7:0] REG_CAP34 = 8'h01;
   localparam logic [7:0] REG_CAP56 = 8'h02;
   localparam logic [7:0] REG_TBS = 8'h03;
   localparam logic [7:0] REG_EDIV = 8'h04;
   localparam logic [7:0] REG_BPTR = 8'h05;
   localparam logic [7:0] REG_CSTART = 8'h06;
   localparam logic [7:0] REG_CEND = 8'h07;
   localparam logic [7:0] REG_SEQ = 8'h08;
   localparam logic [7:0] REG_OUTS = 8'h09;
   localparam logic [7:0] RAM_BASE = 8'h80;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int unsigned CTL_FALL = 0;
   localparam int unsigned CTL_RISE = 1;
   localparam int unsigned CTL_FLAG = 2;
   localparam int unsigned CTL_ENA = 3;
   localparam int unsigned CTL_HI = 4;
   localparam int unsigned TBS_FAST = 4;
   localparam int unsigned TBS_MODEB = 5;
   localparam int unsigned SEQ_FLAG = 0;
   localparam int unsigned SEQ_ENA = 1;
   localparam int unsigned CW_PID_LSB = 20;
   localparam int unsigned SC_TYPE = 0;
   localparam int unsigned SC_PIN_LSB = 10;
   localparam int unsigned SC_IRQ = 13;
   localparam int unsigned SC_OPP = 14;
   localparam int unsigned SC_SET = 15;
   localparam int unsigned SC_CMP_LSB = 16;
   localparam int unsigned VT_VAL_LSB = 1;
   localparam int unsigned VT_D16 = 16;
   localparam int unsigned VT_IRQ = 17;
   localparam int unsigned VT_EN = 18;
   localparam int unsigned VT_RANGE = 19;
   localparam int unsigned VT_MLO_LSB = 20;
   localparam int unsigned VT_RAD_LSB = 23;
   // ------------------------------------------------------------
   // reset values and fixed slots
   // ------------------------------------------------------------
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [7:0] TBS_RST = 8'h00;
   localparam logic [2:0] EDIV_RST = 3'h0;
   localparam logic [4:0] BPTR_RST = 5'h1c;
   localparam logic [4:0] CSTART_RST = 5'h0f;
   localparam logic [4:0] CEND_RST = 5'h00;
   localparam logic [4:0] IMG_WORD = 5'h1f;
   localparam logic [4:0] DED_TOP = 5'h1e;
   localparam logic [4:0] BUF_TOP_A = 5'h1c;
   localparam logic [4:0] BUF_TOP_B = 5'h1a;
   localparam logic [2:0] DIV8_LAST = 3'h7;
   localparam logic [3:0] PRE_ZERO_LAST = 4'h1;
   typedef enum logic {RDCC_IDLE, RDCC_RUN} rdcc_seq_t;
endpackage

/* File: rdcc_cap_in.sv */
// one capture input: synchroniser, edge select and edge prescaler
`timescale 1ns/1ps
module rdcc_cap_in (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   // pin and setup
   input wire logic pin,
   input wire logic rise_sel,
   input wire logic fall_sel,
   input wire logic use_div,
   input wire logic [2:0] div_sel,
   // events
   output logic edge_evt,
   output logic cap_evt
);
   logic s1_q, s2_q, s3_q;
   logic [2:0] cnt_q, cnt_d;

   // s1 is read only by s2; edges are taken between s2 and s3
   always_comb begin
      edge_evt = (rise_sel & s2_q & ~s3_q) | (fall_sel & ~s2_q & s3_q);
      cap_evt = 1'b0;
      cnt_d = cnt_q;
      if (edge_evt) begin
         if (!use_div || cnt_q == div_sel) begin
            cap_evt = 1'b1;
            cnt_d = 3'h0;
         end else begin
            cnt_d = cnt_q + 3'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         cnt_q <= 3'h0;
      end else if (ce) begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         cnt_q <= cnt_d;
      end
   end
endmodule

/* File: rdcc_top.sv */
// ram driven capture compare engine with register port and shared ram
`timescale 1ns/1ps
module rdcc_top import rdcc_pkg::*; (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // pins
   input wire logic [NUM_CAP-1:0] capture_input,
   output logic [NUM_OUT-1:0] compare_outputs,
   // interrupt requests
   output logic capture_irq_req,
   output logic seq_irq_req
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0] ctl_q [0:2];
   logic [7:0] ctl_d [0:2];
   logic [7:0] tbs_q, tbs_d;
   logic [2:0] ediv_q, ediv_d;
   logic [4:0] bptr_q, bptr_d;
   logic [4:0] cstart_q, cstart_d;
   logic [4:0] cend_q, cend_d;
   logic [1:0] seq_q, seq_d;
   logic [7:0] rdata_d;
   logic [31:0] ram_q [0:RAM_WORDS-1];
   logic [31:0] ram_d [0:RAM_WORDS-1];
   logic [RAM_WORDS-1:0] lsb_q, lsb_d;
   logic [NUM_CAP-1:0] pend_q, pend_d;
   logic [TIMER_W-1:0] timer_q, timer_d;
   logic [EVT_W-1:0] evt_q, evt_d;
   logic [3:0] pre_q, pre_d;
   logic [2:0] d8_q, d8_d;
   rdcc_seq_t st_q, st_d;
   logic [4:0] sidx_q, sidx_d;
   logic [OPND_W-1:0] opnd_q, opnd_d;
   logic [NUM_OUT-1:0] op_q, op_d;

   logic [NUM_CAP-1:0] edge_evt, cap_evt, svc;
   logic mode_b, tick;
   logic [3:0] pre_last;
   logic [2:0] sel;
   logic svc_any, svc_ded;
   logic [4:0] svc_word, buf_top, buf_nxt;
   logic [31:0] cap_word;
   logic [3:0] pid;
   logic [31:0] cur;
   logic [OPND_W-1:0] vt_val, vt_max, vt_nv;
   logic vt_exec, vt_wrap, sc_exec, sc_hit, sc_zero, seq_set;
   logic [2:0] sc_pin;
   logic cpu_ram_wr;
   logic [4:0] cpu_word;
   logic [4:0] cpu_lane;

   assign mode_b = tbs_q[TBS_MODEB];
   assign cpu_ram_wr = reg_wr && reg_addr >= RAM_BASE;
   assign cpu_word = reg_addr[6:2];
   // most significant byte sits at the lowest address of a word
   assign cpu_lane = {~reg_addr[1:0], 3'b000};

   // ------------------------------------------------------------
   // capture inputs
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_CAP; g++) begin : g_cap
         rdcc_cap_in u_cap (
            .core_clk(core_clk),
            .rstn(rstn),
            .ce(ce),
            .pin(capture_input[g]),
            .rise_sel(ctl_q[g/2][(g%2)*CTL_HI+CTL_RISE]),
            .fall_sel(ctl_q[g/2][(g%2)*CTL_HI+CTL_FALL]),
            .use_div(g >= 2),
            .div_sel(ediv_q),
            .edge_evt(edge_evt[g]),
            .cap_evt(cap_evt[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // time base
   // ------------------------------------------------------------
   always_comb begin
      pre_last = (tbs_q[3:0] == 4'h0) ? PRE_ZERO_LAST : tbs_q[3:0];
      tick = 1'b0;
      pre_d = pre_q + 4'h1;
      d8_d = d8_q;
      if (pre_q >= pre_last) begin
         pre_d = 4'h0;
         d8_d = d8_q + 3'h1;
         tick = tbs_q[TBS_FAST] || d8_q == DIV8_LAST;
      end
      timer_d = tick ? timer_q + 20'h00001 : timer_q;
      evt_d = edge_evt[NUM_CAP-1] ? evt_q + 8'h01 : evt_q;
   end

   // ------------------------------------------------------------
   // capture service, one slot write per cycle
   // ------------------------------------------------------------
   always_comb begin
      svc = '0;
      sel = 3'h0;
      svc_any = 1'b0;
      for (int i = 0; i < NUM_CAP; i++) begin
         if (pend_q[i] && !svc_any) begin
            svc[i] = 1'b1;
            sel = 3'(i);
            svc_any = 1'b1;
         end
      end
      // new events stay pending even if serviced this cycle
      pend_d = (pend_q & ~svc) | cap_evt;
      svc_ded = mode_b ? (sel < 3'h4) : (sel < 3'h2);
      buf_top = mode_b ? BUF_TOP_B : BUF_TOP_A;
      if (bptr_q > buf_top || {1'b0, bptr_q} <= {1'b0, cstart_q} + 6'h01) begin
         buf_nxt = buf_top;
      end else begin
         buf_nxt = bptr_q - 5'h01;
      end
      svc_word = svc_ded ? 5'(DED_TOP - {2'b00, sel}) : buf_nxt;
      pid = (sel >= 3'h2) ? 4'(4'h1 << (sel - 3'h2)) : 4'h0;
      cap_word = {evt_q, pid, timer_q};
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_comb begin
      cur = ram_q[sidx_q];
      vt_exec = st_q == RDCC_RUN && !cur[SC_TYPE] && !cur[VT_D16];
      sc_exec = st_q == RDCC_RUN && cur[SC_TYPE];
      vt_val = {cur[VT_VAL_LSB +: 15], lsb_q[sidx_q]};
      if (cur[VT_RANGE]) begin
         vt_max = {cur[VT_MLO_LSB +: 3], cur[VT_RAD_LSB +: 9], 4'h0};
      end else begin
         vt_max = {3'h0, cur[VT_RAD_LSB +: 9], cur[VT_MLO_LSB +: 3], 1'b0};
      end
      vt_wrap = vt_val >= vt_max;
      vt_nv = vt_val;
      if (cur[VT_EN]) begin
         vt_nv = vt_wrap ? 16'h0000 : vt_val + 16'h0001;
      end
      sc_pin = cur[SC_PIN_LSB +: 3];
      sc_hit = opnd_q == cur[SC_CMP_LSB +: 16];
      sc_zero = opnd_q == 16'h0000;
      seq_set = 1'b0;
      st_d = st_q;
      sidx_d = sidx_q;
      opnd_d = opnd_q;
      op_d = op_q;
      if (sc_exec) begin
         if (sc_hit) begin
            op_d[sc_pin] = cur[SC_SET];
            seq_set = cur[SC_IRQ];
         end else if (cur[SC_OPP] && sc_zero) begin
            op_d[sc_pin] = ~cur[SC_SET];
         end
      end
      if (vt_exec) begin
         opnd_d = vt_nv;
         seq_set = cur[VT_EN] && vt_wrap && cur[VT_IRQ];
      end
      if (st_q == RDCC_RUN) begin
         if (sidx_q == cend_q || sidx_q == 5'h00) begin
            st_d = RDCC_IDLE;
         end else begin
            sidx_d = sidx_q - 5'h01;
         end
      end
      // a late pass is cut short by the next tick rather than overrun it
      if (tick) begin
         st_d = RDCC_RUN;
         sidx_d = cstart_q;
         opnd_d = timer_d[OPND_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // shared ram: image, sequencer, capture, then cpu wins
   // ------------------------------------------------------------
   always_comb begin
      for (int w = 0; w < RAM_WORDS; w++) begin
         ram_d[w] = ram_q[w];
      end
      lsb_d = lsb_q;
      if (tick) begin
         ram_d[IMG_WORD] = {evt_q, ctl_q[2][CTL_HI+CTL_FLAG], ctl_q[2][CTL_FLAG],
                            ctl_q[1][CTL_HI+CTL_FLAG], ctl_q[1][CTL_FLAG], timer_d};
      end
      if (vt_exec && cur[VT_EN]) begin
         ram_d[sidx_q][VT_VAL_LSB +: 15] = vt_nv[15:1];
         lsb_d[sidx_q] = vt_nv[0];
      end
      if (svc_any) begin
         ram_d[svc_word] = cap_word;
      end
      if (cpu_ram_wr) begin
         ram_d[cpu_word][cpu_lane +: 8] = reg_wdata;
      end
   end

   // ------------------------------------------------------------
   // registers and read port
   // ------------------------------------------------------------
   always_comb begin
      ctl_d = ctl_q;
      tbs_d = tbs_q;
      ediv_d = ediv_q;
      bptr_d = bptr_q;
      cstart_d = cstart_q;
      cend_d = cend_q;
      seq_d = seq_q;
      if (reg_wr) begin
         if (reg_addr == REG_CAP12) begin
            ctl_d[0] = reg_wdata;
         end else if (reg_addr == REG_CAP34) begin
            ctl_d[1] = reg_wdata;
         end else if (reg_addr == REG_CAP56) begin
            ctl_d[2] = reg_wdata;
         end else if (reg_addr == REG_TBS) begin
            tbs_d = {2'b00, reg_wdata[5:0]};
         end else if (reg_addr == REG_EDIV) begin
            ediv_d = reg_wdata[2:0];
         end else if (reg_addr == REG_BPTR) begin
            bptr_d = reg_wdata[4:0];
         end else if (reg_addr == REG_CSTART) begin
            cstart_d = reg_wdata[4:0];
         end else if (reg_addr == REG_CEND) begin
            cend_d = reg_wdata[4:0];
         end else if (reg_addr == REG_SEQ) begin
            seq_d = reg_wdata[1:0];
         end
      end
      // hardware sets win over a software clear in the same cycle
      for (int i = 0; i < NUM_CAP; i++) begin
         if (svc[i]) begin
            ctl_d[i/2][(i%2)*CTL_HI+CTL_FLAG] = 1'b1;
         end
      end
      if (svc_any && !svc_ded) begin
         bptr_d = svc_word;
      end
      if (seq_set) begin
         seq_d[SEQ_FLAG] = 1'b1;
      end
      rdata_d = 8'h00;
      if (reg_rd) begin
         if (reg_addr == REG_CAP12) begin
            rdata_d = ctl_q[0];
         end else if (reg_addr == REG_CAP34) begin
            rdata_d = ctl_q[1];
         end else if (reg_addr == REG_CAP56) begin
            rdata_d = ctl_q[2];
         end else if (reg_addr == REG_TBS) begin
            rdata_d = tbs_q;
         end else if (reg_addr == REG_EDIV) begin
            rdata_d = {5'h00, ediv_q};
         end else if (reg_addr == REG_BPTR) begin
            rdata_d = {3'h0, bptr_q};
         end else if (reg_addr == REG_CSTART) begin
            rdata_d = {3'h0, cstart_q};
         end else if (reg_addr == REG_CEND) begin
            rdata_d = {3'h0, cend_q};
         end else if (reg_addr == REG_SEQ) begin
            rdata_d = {6'h00, seq_q};
         end else if (reg_addr == REG_OUTS) begin
            rdata_d = op_q;
         end else if (reg_addr >= RAM_BASE) begin
            rdata_d = ram_q[cpu_word][cpu_lane +: 8];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         for (int r = 0; r < 3; r++) begin
            ctl_q[r] <= CTL_RST;
         end
         for (int w = 0; w < RAM_WORDS; w++) begin
            ram_q[w] <= 32'h00000000;
         end
         tbs_q <= TBS_RST;
         ediv_q <= EDIV_RST;
         bptr_q <= BPTR_RST;
         cstart_q <= CSTART_RST;
         cend_q <= CEND_RST;
         seq_q <= 2'b00;
         reg_rdata <= 8'h00;
         lsb_q <= '0;
         pend_q <= '0;
         timer_q <= '0;
         evt_q <= '0;
         pre_q <= 4'h0;
         d8_q <= 3'h0;
         st_q <= RDCC_IDLE;
         sidx_q <= 5'h00;
         opnd_q <= '0;
         op_q <= '0;
      end else if (ce) begin
         ctl_q <= ctl_d;
         ram_q <= ram_d;
         tbs_q <= tbs_d;
         ediv_q <= ediv_d;
         bptr_q <= bptr_d;
         cstart_q <= cstart_d;
         cend_q <= cend_d;
         seq_q <= seq_d;
         reg_rdata <= rdata_d;
         lsb_q <= lsb_d;
         pend_q <= pend_d;
         timer_q <= timer_d;
         evt_q <= evt_d;
         pre_q <= pre_d;
         d8_q <= d8_d;
         st_q <= st_d;
         sidx_q <= sidx_d;
         opnd_q <= opnd_d;
         op_q <= op_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   always_comb begin
      capture_irq_req = 1'b0;
      for (int i = 0; i < NUM_CAP; i++) begin
         capture_irq_req = capture_irq_req | (ctl_q[i/2][(i%2)*CTL_HI+CTL_FLAG]
                           & ctl_q[i/2][(i%2)*CTL_HI+CTL_ENA]);
      end
   end
   assign seq_irq_req = seq_q[SEQ_FLAG] & seq_q[SEQ_ENA];
   assign compare_outputs = op_q;
endmodule

/* File: rdcc_sva.sv */
// port assertions of the capture compare engine
`timescale 1ns/1ps
module rdcc_sva import rdcc_pkg::*; (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // pins and requests
   input wire logic [NUM_CAP-1:0] capture_input,
   input wire logic [NUM_OUT-1:0] compare_outputs,
   input wire logic capture_irq_req,
   input wire logic seq_irq_req
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   // ------------------------------------------------------------
   // sequences
   // ------------------------------------------------------------
   // write then read of one place, back to back
   sequence s_wr_rd(logic [7:0] a);
      reg_wr && ce && reg_addr == a ##1 reg_rd && ce && reg_addr == a;
   endsequence
   sequence s_rd(logic [7:0] a);
      reg_rd && ce && reg_addr == a;
   endsequence
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_reset_quiet: assert property (disable iff (1'b0) !rstn && ce |=> reg_rdata == 8'h00
      && compare_outputs == 8'h00 && !seq_irq_req && !capture_irq_req) else $error("state not cleared by reset");
   a_rdata_idle: assert property (ce && !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (reg_rd && ce && reg_addr inside {[8'h0a:8'h7f]} |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_outs_readback: assert property (s_rd(REG_OUTS) |=> reg_rdata == $past(compare_outputs))
      else $error("output readback differs from pins");
   a_seq_irq_gate: assert property (s_rd(REG_SEQ) |=>
      (reg_rdata[SEQ_FLAG] && reg_rdata[SEQ_ENA]) == $past(seq_irq_req)) else $error("seq request not flag and enable");
   a_seq_mask_off: assert property (reg_wr && ce && reg_addr == REG_SEQ && !reg_wdata[SEQ_ENA] |=> !seq_irq_req)
      else $error("seq request with enable cleared");
   a_start_rw: assert property (s_wr_rd(REG_CSTART) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h1f))
      else $error("command start readback wrong");
   a_end_rw: assert property (s_wr_rd(REG_CEND) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h1f))
      else $error("command end readback wrong");
   a_setup_rw: assert property (s_wr_rd(REG_TBS) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h3f))
      else $error("setup readback wrong");
   a_ediv_rw: assert property (s_wr_rd(REG_EDIV) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h07))
      else $error("edge count readback wrong");
   a_ce_freeze: assert property (!ce |=> $stable(compare_outputs) && $stable(capture_irq_req))
      else $error("outputs moved while clock enable low");
endmodule

bind rdcc_top rdcc_sva rdcc_sva_inst (
   .core_clk(core_clk),
   .rstn(rstn),
   .ce(ce),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .capture_input(capture_input),
   .compare_outputs(compare_outputs),
   .capture_irq_req(capture_irq_req),
   .seq_irq_req(seq_irq_req)
);

/* File: rdcc_pin_model.sv */
// capture signal sources outside the engine
`timescale 1ns/1ps
module rdcc_pin_model import rdcc_pkg::*; (
   // clock
   input wire logic core_clk,
   // pins toward the engine
   output logic [NUM_CAP-1:0] pins
);
   initial pins = '0;
   // four cycles each way, four times the single sample the synchroniser needs
   task automatic drive(input int idx);
      @(posedge core_clk);
      pins[idx] <= 1'b1;
      repeat (4) @(posedge core_clk);
      pins[idx] <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask
endmodule

/* File: rdcc_top_tb.sv */
// self-checking bench of the capture compare engine
`timescale 1ns/1ps
module rdcc_top_tb import rdcc_pkg::*;;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [NUM_CAP-1:0] capture_input;
   logic [NUM_OUT-1:0] compare_outputs;
   logic capture_irq_req;
   logic seq_irq_req;
   int bad_count = 0;
   int check_count = 0;
   always #2.5 core_clk = ~core_clk;
   rdcc_top rdcc_top_inst (
      .core_clk(core_clk),
      .rstn(rstn),
      .ce(ce),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .capture_input(capture_input),
      .compare_outputs(compare_outputs),
      .capture_irq_req(capture_irq_req),
      .seq_irq_req(seq_irq_req)
   );
   rdcc_pin_model rdcc_pin_model_inst (.core_clk(core_clk), .pins(capture_input));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // strobes are left up; the next access or idle sets them again
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk8(reg_rdata & m, exp);
      @(posedge core_clk);
   endtask
   task automatic wrrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
      wr(a, d);
      rchk(a, m, d & m);
   endtask
   task automatic idle(input int n);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask
   task automatic pulse(input int i);
      idle(1);
      rdcc_pin_model_inst.drive(i);
      idle(10);
   endtask
   function automatic logic [7:0] ba(input logic [4:0] w, input logic [1:0] b);
      return RAM_BASE | {1'b0, w, b};
   endfunction
   // low byte first, so a half written word never reads as a timer definition
   task automatic wrd(input logic [4:0] w, input logic [31:0] v);
      for (int b = 3; b >= 0; b--) begin
         wr(ba(w, b[1:0]), v[31-8*b -: 8]);
      end
   endtask
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      logic [7:0] ra [10];
      logic [7:0] re [10];
      int n;
      ra = '{REG_CAP12, REG_CAP34, REG_CAP56, REG_TBS, REG_EDIV, REG_BPTR, REG_CSTART, REG_CEND, REG_SEQ, REG_OUTS};
      re = '{CTL_RST, CTL_RST, CTL_RST, TBS_RST, {5'h00, EDIV_RST}, {3'h0, BPTR_RST}, {3'h0, CSTART_RST},
         {3'h0, CEND_RST}, 8'h00, 8'h00};
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      for (int i = 0; i < 10; i++) begin
         rchk(ra[i], 8'hff, re[i]);
      end
      wr(8'h0a, 8'h55);
      rchk(8'h0a, 8'hff, 8'h00);
      rchk(8'h7f, 8'hff, 8'h00);
      wrrd(REG_CSTART, 8'h0f, 8'h1f);
      wr(REG_CAP12, 8'h0a);
      pulse(0);
      rchk(REG_CAP12, 8'hff, 8'h0e);
      chk1(capture_irq_req, 1'b1);
      wr(REG_CAP12, 8'h0a);
      rchk(ba(DED_TOP, 0), 8'hff, 8'h00);
      rchk(ba(DED_TOP, 1), 8'hf0, 8'h00);
      rchk(REG_CAP12, 8'hff, 8'h0a);
      chk1(capture_irq_req, 1'b0);
      // a pulse while the enable is low is never seen
      ce <= 1'b0;
      pulse(0);
      ce <= 1'b1;
      rchk(REG_CAP12, 8'hff, 8'h0a);
      wrrd(REG_EDIV, 8'h01, 8'h07);
      wr(REG_BPTR, 8'h00);
      wr(REG_CAP34, 8'h02);
      pulse(2);
      rchk(REG_CAP34, 8'hff, 8'h02);
      pulse(2);
      rchk(REG_CAP34, 8'hff, 8'h06);
      rchk(REG_BPTR, 8'hff, {3'h0, BUF_TOP_A});
      rchk(ba(BUF_TOP_A, 1), 8'hf0, 8'h10);
      pulse(5);
      idle(40);
      rchk(ba(IMG_WORD, 0), 8'hff, 8'h00);
      wr(REG_CAP56, 8'h30);
      pulse(5);
      idle(40);
      rchk(ba(IMG_WORD, 0), 8'hff, 8'h02);
      rchk(REG_CAP56, 8'hff, 8'h70);
      rchk(REG_BPTR, 8'hff, {3'h0, BUF_TOP_A - 5'h01});
      rchk(ba(BUF_TOP_A - 5'h01, 1), 8'hf0, 8'h80);
      wrrd(REG_TBS, 8'h20, 8'h3f);
      wrrd(REG_EDIV, 8'h00, 8'h07);
      wr(REG_CAP34, 8'h20);
      pulse(3);
      rchk(REG_CAP34, 8'hff, 8'h60);
      rchk(ba(DED_TOP - 5'h03, 1), 8'hf0, 8'h20);
      rchk(REG_BPTR, 8'hff, {3'h0, BUF_TOP_A - 5'h01});
      wrrd(REG_TBS, 8'h11, 8'h3f);
      wrrd(REG_CEND, 8'h0e, 8'h1f);
      wrd(5'h0f, 32'h0400_ac01);
      wrd(5'h0e, 32'h0410_0c01);
      wr(REG_SEQ, 8'h02);
      idle(1);
      n = 0;
      while (compare_outputs[3] !== 1'b1 && n < 3000) begin
         @(posedge core_clk);
         n++;
      end
      rchk(REG_OUTS, 8'hff, 8'h08);
      rchk(REG_SEQ, 8'hff, 8'h03);
      chk1(seq_irq_req, 1'b1);
      idle(1);
      n = 0;
      while (compare_outputs[3] !== 1'b0 && n < 100) begin
         @(posedge core_clk);
         n++;
      end
      chk1(compare_outputs[3], 1'b0);
      wr(REG_SEQ, 8'h00);
      rchk(REG_SEQ, 8'hff, 8'h00);
      wrd(5'h0d, 32'h0026_0000);
      // only two entries fit between ticks two cycles apart
      wr(REG_CSTART, 8'h0e);
      wr(REG_CEND, 8'h0d);
      wr(REG_SEQ, 8'h02);
      idle(1);
      n = 0;
      while (seq_irq_req !== 1'b1 && n < 40) begin
         @(posedge core_clk);
         n++;
      end
      chk1(seq_irq_req, 1'b1);
      wr(REG_SEQ, 8'h02);
      idle(1);
      n = 0;
      while (seq_irq_req !== 1'b1 && n < 40) begin
         @(posedge core_clk);
         n++;
      end
      chk1(seq_irq_req === 1'b1 && n < 12, 1'b1);
      end_of_test;
   end
   // a hang is cut well past the few thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      end_of_test;
   end
endmodule
